// [hdl/sasr_regs.v]
// Summary of operation
// - In initiator mode the ACK pin is driven with the inverse of bit 7 of the phase control register.
// - Reading bit 7 of the phase control register returns the inverse of the ACK pin level.
// - The sync control register clears on bus reset low, device reset low, or a host/buffer reset write.
// - The low four bits of the sync control register give the offset count, one to 15 pairs.
`timescale 1ns/1ns
`include "sasr_map.vh"
module sasr_regs (
	input  wire       sys_clk,
	input  wire       resetn,
	input  wire       scsi_rst_n,
	input  wire       initiator_en,
	input  wire       ack_in,
	output reg        ack_out,
	output reg        ack_oe,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	output reg  [3:0] sync_offset,
	output reg        sync_enable
);
	wire       rst_n_sys;
	wire       bus_rst_n_s;
	wire       ack_in_s;
	reg  [7:0] bus_phase_control;
	reg  [7:0] sync_transfer_control;
	reg  [7:0] next_rdata;
	wire       host_reset;
	wire       clear_regs;

	// Reset release is synchronised; assertion stays asynchronous
	sasr_sync2 #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
		.clk    (sys_clk),
		.arst_n (resetn),
		.d      (1'b1),
		.q      (rst_n_sys)
	);

	// Bus reset and ACK pins pass through two synchroniser stages
	sasr_sync2 #(.WIDTH(2), .INIT(1'b1)) u_pin_sync (
		.clk    (sys_clk),
		.arst_n (rst_n_sys),
		.d      ({scsi_rst_n, ack_in}),
		.q      ({bus_rst_n_s, ack_in_s})
	);

	assign host_reset = wr && (addr == `SASR_ADDR_HOST_RESET) &&
		wdata[`SASR_HOST_RESET_BIT];
	assign clear_regs = !bus_rst_n_s || host_reset;

	always @(posedge sys_clk or negedge rst_n_sys) begin
		if (!rst_n_sys) begin
			bus_phase_control     <= `SASR_PHASE_RESET;
			sync_transfer_control <= `SASR_SYNC_RESET;
		end else if (clear_regs) begin
			bus_phase_control     <= `SASR_PHASE_RESET;
			sync_transfer_control <= `SASR_SYNC_RESET;
		end else if (wr) begin
			if (addr == `SASR_ADDR_PHASE_CTRL)
				bus_phase_control <= wdata;
			if (addr == `SASR_ADDR_SYNC_CTRL)
				sync_transfer_control <= wdata;
		end
	end

	always @* begin
		next_rdata = 8'h00;
		if (addr == `SASR_ADDR_PHASE_CTRL) begin
			next_rdata = bus_phase_control;
			// Bit 7 reflects the wire, not the stored value
			next_rdata[`SASR_PHASE_ACK_BIT] = ~ack_in_s;
		end else if (addr == `SASR_ADDR_SYNC_CTRL) begin
			next_rdata = sync_transfer_control;
		end
	end

	always @(posedge sys_clk or negedge rst_n_sys) begin
		if (!rst_n_sys) begin
			rdata       <= 8'h00;
			ack_out     <= 1'b1;
			ack_oe      <= 1'b0;
			sync_offset <= `SASR_OFFSET_ASYNC;
			sync_enable <= 1'b0;
		end else begin
			if (rd)
				rdata <= next_rdata;
			else
				rdata <= 8'h00;
			// Pin level is the inverse of the stored bit
			ack_out <= ~bus_phase_control[`SASR_PHASE_ACK_BIT];
			ack_oe  <= initiator_en;
			sync_offset <= sync_transfer_control[`SASR_OFFSET_MSB:
				`SASR_OFFSET_LSB];
			// Zero means asynchronous; 4 bits cannot express unlimited
			sync_enable <= |sync_transfer_control[`SASR_OFFSET_MSB:
				`SASR_OFFSET_LSB];
		end
	end
endmodule // sasr_regs

// [include/sasr_map.vh]
`ifndef SASR_MAP_VH
`define SASR_MAP_VH

`define SASR_ADDR_PHASE_CTRL  8'h42
`define SASR_ADDR_SYNC_CTRL   8'h43
`define SASR_ADDR_HOST_RESET  8'h53

`define SASR_PHASE_ACK_BIT    7
`define SASR_HOST_RESET_BIT   5
`define SASR_OFFSET_LSB       0
`define SASR_OFFSET_MSB       3

`define SASR_PHASE_RESET      8'h00
`define SASR_SYNC_RESET       8'h00
`define SASR_OFFSET_ASYNC     4'h0

`endif

// [hdl/sasr_sync2.v]
`timescale 1ns/1ns
module sasr_sync2 #(
	parameter          WIDTH = 1,
	parameter [0:0]    INIT  = 1'b0
) (
	input  wire             clk,
	input  wire             arst_n,
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta;

	// The first stage feeds only the second stage
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= {WIDTH{INIT}};
			q    <= {WIDTH{INIT}};
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // sasr_sync2

// [test/sasr_regs_checker.sv]
`timescale 1ns/1ns
module sasr_regs_checker (
	input wire       sys_clk,
	input wire       resetn,
	input wire       scsi_rst_n,
	input wire       ack_in,
	input wire       ack_out,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire       wr,
	input wire       rd,
	input wire [7:0] rdata,
	input wire [3:0] sync_offset,
	input wire       sync_enable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire ok = scsi_rst_n;
	// Bus reset reaches the registers two edges late, so gate on its past
	a_ack_drive: assert property ($past(ok, 2) && wr && addr == 8'h42
		|=> ##1 ack_out == !$past(wdata[7], 2)) else $error("ack");
	a_ack_read: assert property (rd && addr == 8'h42 && $stable(ack_in)
		&& ack_in == $past(ack_in, 2) |=> rdata[7] == !$past(ack_in))
		else $error("ackrd");
	a_bus_clear: assert property (!scsi_rst_n [*3] |-> ##2
		sync_offset == 4'h0) else $error("clr");
	a_offset_copy: assert property (ok && $past(ok, 2) && wr
		&& addr == 8'h43 |=> ##1 sync_offset == $past(wdata[3:0], 2))
		else $error("ofs");
	a_async_sel: assert property (sync_enable == (sync_offset != 4'h0))
		else $error("en");
	cover property (wr && addr == 8'h43);
	cover property (rd && addr == 8'h42);
	cover property (!scsi_rst_n [*3]);
endmodule // sasr_regs_checker
bind sasr_regs sasr_regs_checker u_chk (.*);

// [test/sasr_ack_peer.sv]
`timescale 1ns/1ns
module sasr_ack_peer (
	input  wire ack_oe,
	input  wire ack_out,
	input  wire peer_ack,
	output wire ack_in
);
	// Peer high means released; with ack_oe low, ack_in follows peer_ack directly
	assign ack_in = ack_oe ? ack_out : peer_ack;
endmodule // sasr_ack_peer

// [test/sasr_regs_tb_top.sv]
`timescale 1ns/1ns
module sasr_regs_tb_top;
	reg sys_clk = 0, resetn = 0, scsi_rst_n = 1, initiator_en = 1;
	reg wr = 0, rd = 0, peer_ack = 1;
	reg [7:0] addr = 0, wdata = 0;
	wire ack_in, ack_out, ack_oe, sync_enable;
	wire [7:0] rdata;
	wire [3:0] sync_offset;
	int error_cnt = 0, n_compared = 0, i;
	reg [31:0] rows [8] = '{32'h43014301, 32'h430f430f, 32'h43f043f0,
		32'h42804280, 32'h42004200, 32'h53204300, 32'h44114400, 32'h43094309};
	always #20 sys_clk = ~sys_clk;
	sasr_regs u_dut (.*);
	sasr_ack_peer u_peer (.*);
	task final_report;
		$display("compared %0d bad %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task op(input [31:0] r);
		@(posedge sys_clk) {addr, wdata, wr} <= {r[31:16], 1'b1};
		@(posedge sys_clk) wr <= 0;
		repeat (4) @(posedge sys_clk);
		{addr, rd} <= {r[15:8], 1'b1};
		@(posedge sys_clk) rd <= 0;
		@(negedge sys_clk) n_compared++;
		if (rdata !== r[7:0]) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, rdata, r[7:0]);
		end
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		resetn <= 1;
		repeat (3) @(posedge sys_clk);
		for (i = 0; i < 8; i++) op(rows[i]);
		@(negedge sys_clk) chk({3'h0, sync_enable, sync_offset}, 8'h19);
		$display("rows done");
		@(posedge sys_clk) {initiator_en, peer_ack} <= 0;
		op(32'h42004280);
		chk({6'h00, ack_oe, ack_out}, 8'h01);
		@(posedge sys_clk) scsi_rst_n <= 0;
		op(32'h43074300);
		chk({3'h0, sync_enable, sync_offset}, 8'h00);
		$display("hand done");
		final_report;
	end
	initial begin
		#200000;
		error_cnt++;
		final_report;
	end
endmodule // sasr_regs_tb_top
